// File: design/ssr_map.svh
// Constants for the speed search and auto restart block
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH
`define SSR_SEL_ACCEL       0
`define SSR_SEL_FAULT_RST   1
`define SSR_SEL_POWER_FAIL  2
`define SSR_SEL_POWER_ON    3
`define SSR_ILIM_MIN        8'd80
`define SSR_ILIM_MAX        8'd200
`define SSR_ILIM_DEF        8'd100
`define SSR_KP_DEF          14'd100
`define SSR_KI_DEF          14'd1000
`define SSR_FUNC_SEARCH     5'd15
`define SSR_ATTEMPT_MAX     4'd10
`define SSR_DELAY_MAX_S     6'd60
`define SSR_QUIET_S         30
`define SSR_CLK_HZ          100000000
`define SSR_TICK_CYCLES     (`SSR_CLK_HZ / 10)
`define SSR_QUIET_TICKS     (`SSR_QUIET_S * 10)
`define SSR_VOLT_NOM        16'hFFFF
`endif

// File: design/ssr_pkg.sv
// Types for the speed search and auto restart block
package ssr_pkg;
	typedef enum logic [5:0] {
		SSR_IDLE   = 6'b000001,
		SSR_RUN    = 6'b000010,
		SSR_TRIP   = 6'b000100,
		SSR_WAIT   = 6'b001000,
		SSR_SEARCH = 6'b010000,
		SSR_LOCK   = 6'b100000
	} ssr_state_e;
	typedef struct packed {
		logic [13:0] kp;
		logic [13:0] ki;
		logic [7:0]  ilim_pct;
	} ssr_pi_cfg_s;
	typedef struct packed {
		logic [15:0] freq;
		logic [15:0] volt;
	} ssr_drive_s;
endpackage

// File: design/ssr_tick.sv
// Tenth-second tick generator
`timescale 1ns/1ps
module ssr_tick
	import ssr_pkg::*;
#(
	parameter int TICK_CYCLES = 10000000
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic ce,
	// Tick
	output logic      tick
);
	logic [23:0] cnt_q;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt_q <= 24'h000000;
			tick  <= 1'b0;
		end else if (ce) begin
			tick  <= (cnt_q == 24'(TICK_CYCLES - 1));
			cnt_q <= (cnt_q == 24'(TICK_CYCLES - 1)) ? 24'h000000 : cnt_q + 24'h000001;
		end
	end
endmodule

// File: design/ssr_pi.sv
// PI loop steering output voltage and frequency during search
`timescale 1ns/1ps
`include "ssr_map.svh"
module ssr_pi
	import ssr_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        ce,
	// Control
	input  wire logic        start,
	input  wire logic        active,
	input  wire ssr_pi_cfg_s cfg,
	input  wire logic [15:0] hold_freq,
	input  wire logic [15:0] motor_current,
	input  wire logic [15:0] motor_rated_current,
	// Result
	output ssr_drive_s       drive,
	output logic             over_limit,
	output logic             done
);
	logic [23:0] lim_full;
	logic [15:0] lim;
	logic [15:0] err;
	logic [31:0] pterm;
	logic [31:0] iterm;
	logic [31:0] integ_q;
	logic [15:0] step;

	always_comb begin
		lim_full = 24'(motor_rated_current) * 24'(cfg.ilim_pct) / 24'd100;
		lim      = lim_full[15:0];
		err      = (motor_current > lim) ? motor_current - lim : lim - motor_current;
		pterm    = 32'(err) * 32'(cfg.kp);
		iterm    = 32'(err) * 32'(cfg.ki);
		step     = (pterm[31:8] + integ_q[31:16] == 24'h0) ? 16'h0001 : 16'(pterm[31:8] + integ_q[31:16]);
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			drive      <= '0;
			integ_q    <= 32'h0;
			over_limit <= 1'b0;
			done       <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			if (start) begin
				drive.freq <= hold_freq;
				drive.volt <= 16'h0000;
				integ_q    <= 32'h0;
				over_limit <= 1'b0;
			end else if (active) begin
				integ_q    <= integ_q + iterm;
				over_limit <= (motor_current > lim);
				if (motor_current > lim) begin
					drive.freq <= (drive.freq > step) ? drive.freq - step : 16'h0000;
					integ_q    <= 32'h0;
				end else if (drive.volt != `SSR_VOLT_NOM) begin
					drive.volt <= (`SSR_VOLT_NOM - drive.volt > step) ? drive.volt + step : `SSR_VOLT_NOM;
				end else if (drive.freq < hold_freq) begin
					drive.freq <= (hold_freq - drive.freq > step) ? drive.freq + step : hold_freq;
				end else begin
					done <= 1'b1;
				end
			end
		end
	end
endmodule

// File: design/ssr_top.sv
// Speed search and auto restart sequencer
// Notes on behaviour
// - Four select bits enable search cases
// - Search current limited to percent of rated
// - Search is PI loop with own gains
// - Output function 15 shows search active
// - Power loss outside idle raises undervoltage trip, holds output
// - Power return resumes held frequency, raises voltage
// - Over limit: stop voltage rise, lower frequency
// - Under limit: resume voltage, stop lowering
// - Nominal reached: end search, accelerate on
// - After trip wait delay if count nonzero
// - Each restart after delay decrements remaining count
// - Too many trips: no restart, stay stopped
// - Fault reset reloads remaining count
// - Thirty quiet seconds restore the count
// - No restart after undervoltage or emergency stop
// - Delay expiry starts search acceleration
`timescale 1ns/1ps
`include "ssr_map.svh"
module ssr_top
	import ssr_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        ce,
	// Configuration
	input  wire logic [3:0]  search_case_select,
	input  wire logic [7:0]  search_current_limit,
	input  wire logic [13:0] search_prop_gain,
	input  wire logic [13:0] search_integral_gain,
	input  wire logic [4:0]  output_terminal_function,
	input  wire logic [4:0]  relay_output_function,
	input  wire logic [3:0]  restart_attempt_count,
	input  wire logic [5:0]  restart_delay_time,
	input  wire logic        power_on_start,
	input  wire logic        restart_after_fault_reset,
	// Drive events
	input  wire logic        run_cmd,
	input  wire logic        power_ok,
	input  wire logic        fault_trip,
	input  wire logic        emergency_stop,
	input  wire logic        fault_reset,
	input  wire logic [15:0] ref_freq,
	input  wire logic [15:0] motor_current,
	input  wire logic [15:0] motor_rated_current,
	// Outputs
	output ssr_drive_s       drive_out,
	output logic             multi_output_terminal,
	output logic             relay_contact_output,
	output logic             undervoltage_trip,
	output logic             search_active,
	output logic             restart_locked,
	output logic [3:0]       restart_remaining
);
	ssr_state_e  state_q;
	logic [15:0] hold_q;
	logic [9:0]  delay_q;
	logic [9:0]  quiet_q;
	logic        quiet_run_q;
	logic        ps_q;
	logic        search_start;
	logic        tick;
	logic        pi_done;
	logic        pi_over;
	logic        lock_cause_q;
	logic        powered_q;
	logic        fault_rst_q;
	ssr_drive_s  pi_drive;
	ssr_pi_cfg_s cfg;
	logic        trip_evt;

	function automatic logic case_on(input logic [3:0] sel, input int bit_n);
		case_on = sel[bit_n];
	endfunction

	function automatic logic [7:0] clamp_lim(input logic [7:0] v);
		if (v < `SSR_ILIM_MIN)
			clamp_lim = `SSR_ILIM_MIN;
		else if (v > `SSR_ILIM_MAX)
			clamp_lim = `SSR_ILIM_MAX;
		else
			clamp_lim = v;
	endfunction

	always_comb begin
		cfg.kp       = search_prop_gain;
		cfg.ki       = search_integral_gain;
		cfg.ilim_pct = clamp_lim(search_current_limit);
		trip_evt     = fault_trip || emergency_stop || !power_ok;
		search_start = 1'b0;
		if (state_q == SSR_IDLE && run_cmd && power_ok)
			search_start = (!powered_q && power_on_start && case_on(search_case_select, `SSR_SEL_POWER_ON)) ||
				(fault_rst_q && restart_after_fault_reset && case_on(search_case_select, `SSR_SEL_FAULT_RST)) ||
				case_on(search_case_select, `SSR_SEL_ACCEL);
		if (state_q == SSR_TRIP && power_ok && lock_cause_q && case_on(search_case_select, `SSR_SEL_POWER_FAIL))
			search_start = 1'b1;
		if (state_q == SSR_WAIT && delay_q == 10'h000 && !trip_evt)
			search_start = 1'b1;
	end

	ssr_tick #(
		.TICK_CYCLES(`SSR_TICK_CYCLES)
	) u_tick (
		.clk  (clk),
		.rst_b(rst_b),
		.ce   (ce),
		.tick (tick)
	);

	ssr_pi u_pi (
		.clk                (clk),
		.rst_b              (rst_b),
		.ce                 (ce),
		.start              (search_start),
		.active             (state_q == SSR_SEARCH && !trip_evt),
		.cfg                (cfg),
		.hold_freq          (hold_q),
		.motor_current      (motor_current),
		.motor_rated_current(motor_rated_current),
		.drive              (pi_drive),
		.over_limit         (pi_over),
		.done               (pi_done)
	);

	// Sequencer
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q      <= SSR_IDLE;
			lock_cause_q <= 1'b0;
			delay_q      <= 10'h000;
		end else if (ce) begin
			case (state_q)
				SSR_IDLE: begin
					if (search_start)
						state_q <= SSR_SEARCH;
					else if (run_cmd && power_ok)
						state_q <= SSR_RUN;
				end
				SSR_RUN, SSR_SEARCH: begin
					if (!power_ok) begin
						state_q      <= SSR_TRIP;
						lock_cause_q <= 1'b1;
					end else if (fault_trip || emergency_stop) begin
						lock_cause_q <= emergency_stop;
						delay_q      <= 10'(restart_delay_time) * 10'd10;
						if (emergency_stop)
							state_q <= SSR_LOCK;
						else if (!ps_q)
							state_q <= SSR_LOCK;
						else
							state_q <= SSR_WAIT;
					end else if (state_q == SSR_SEARCH && pi_done)
						state_q <= SSR_RUN;
					else if (!run_cmd)
						state_q <= SSR_IDLE;
				end
				SSR_TRIP: begin
					if (search_start)
						state_q <= SSR_SEARCH;
					else if (power_ok)
						state_q <= SSR_LOCK;
				end
				SSR_WAIT: begin
					if (trip_evt)
						state_q <= SSR_LOCK;
					else if (search_start)
						state_q <= SSR_SEARCH;
					else if (tick)
						delay_q <= delay_q - 10'h001;
				end
				SSR_LOCK: begin
					if (fault_reset)
						state_q <= SSR_IDLE;
				end
				default: state_q <= SSR_IDLE;
			endcase
		end
	end

	// Held frequency and start conditions
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			hold_q      <= 16'h0000;
			powered_q   <= 1'b0;
			fault_rst_q <= 1'b0;
		end else if (ce) begin
			if (state_q == SSR_RUN)
				hold_q <= (ref_freq > drive_out.freq) ? drive_out.freq : ref_freq;
			if (state_q == SSR_IDLE && run_cmd)
				powered_q <= 1'b1;
			if (fault_reset)
				fault_rst_q <= 1'b1;
			else if (state_q == SSR_RUN)
				fault_rst_q <= 1'b0;
		end
	end

	// Remaining restart count and quiet timer
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ps_q        <= 1'b0;
			quiet_q     <= 10'h000;
			quiet_run_q <= 1'b0;
			restart_remaining <= 4'h0;
		end else if (ce) begin
			ps_q <= (restart_remaining != 4'h0);
			if (fault_reset) begin
				restart_remaining <= (restart_attempt_count > `SSR_ATTEMPT_MAX) ? `SSR_ATTEMPT_MAX
					: restart_attempt_count;
				quiet_run_q <= 1'b0;
			end else if (state_q == SSR_WAIT && search_start) begin
				restart_remaining <= restart_remaining - 4'h1;
				quiet_q     <= 10'(`SSR_QUIET_TICKS);
				quiet_run_q <= 1'b1;
			end else if (trip_evt) begin
				quiet_run_q <= 1'b0;
			end else if (quiet_run_q && tick) begin
				if (quiet_q == 10'h001) begin
					restart_remaining <= (restart_attempt_count > `SSR_ATTEMPT_MAX) ? `SSR_ATTEMPT_MAX
						: restart_attempt_count;
					quiet_run_q <= 1'b0;
				end
				quiet_q <= quiet_q - 10'h001;
			end
		end
	end

	// Registered outputs
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			drive_out             <= '0;
			multi_output_terminal <= 1'b0;
			relay_contact_output  <= 1'b0;
			undervoltage_trip     <= 1'b0;
			search_active         <= 1'b0;
			restart_locked        <= 1'b0;
		end else if (ce) begin
			if (state_q == SSR_SEARCH)
				drive_out <= pi_drive;
			else if (state_q == SSR_RUN)
				drive_out <= '{freq: ref_freq, volt: `SSR_VOLT_NOM};
			else if (state_q != SSR_TRIP)
				drive_out <= '0;
			search_active         <= (state_q == SSR_SEARCH) && !pi_done && !trip_evt;
			multi_output_terminal <= (output_terminal_function == `SSR_FUNC_SEARCH) &&
				(state_q == SSR_SEARCH) && !pi_done && !trip_evt;
			relay_contact_output  <= (relay_output_function == `SSR_FUNC_SEARCH) &&
				(state_q == SSR_SEARCH) && !pi_done && !trip_evt;
			undervoltage_trip     <= !power_ok && state_q != SSR_IDLE;
			restart_locked        <= (state_q == SSR_LOCK);
		end
	end
endmodule

// File: test/ssr_monitor.sv
// Assertions on the speed search and auto restart ports
`timescale 1ns/1ps
module ssr_monitor
	import ssr_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_b,
	// Watched inputs
	input wire logic [4:0]  output_terminal_function,
	input wire logic [4:0]  relay_output_function,
	input wire logic [3:0]  restart_attempt_count,
	input wire logic [7:0]  search_current_limit,
	input wire logic        power_ok,
	input wire logic        fault_reset,
	input wire logic        emergency_stop,
	input wire logic [15:0] motor_current,
	input wire logic [15:0] motor_rated_current,
	// Watched outputs
	input wire ssr_drive_s  drive_out,
	input wire logic        multi_output_terminal,
	input wire logic        relay_contact_output,
	input wire logic        undervoltage_trip,
	input wire logic        search_active,
	input wire logic        restart_locked,
	input wire logic [3:0]  restart_remaining
);
	logic [7:0]  pct;
	logic [31:0] lim;
	logic [31:0] cur;
	logic [3:0]  ovr_q;
	logic [3:0]  und_q;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// Clamped search limit
	assign pct = search_current_limit < 8'h50 ? 8'h50 : (search_current_limit > 8'hC8 ? 8'hC8 : search_current_limit);
	assign lim = 32'(motor_rated_current) * 32'(pct) / 32'h64;
	assign cur = 32'(motor_current);
	// Cycles spent over or under the limit in search
	always_ff @(posedge clk) begin
		ovr_q <= (!rst_b || !search_active || cur <= lim) ? 4'h0 : ovr_q + 4'(ovr_q != 4'hF);
	end
	always_ff @(posedge clk) begin
		und_q <= (!rst_b || !search_active || cur > lim) ? 4'h0 : und_q + 4'(und_q != 4'hF);
	end
	chk_term_shows: assert property (output_terminal_function == 5'h0F && search_active
		|-> ##[0:2] (multi_output_terminal || !search_active)) else $error("terminal missed search");
	chk_relay_shows: assert property (relay_output_function == 5'h0F && search_active
		|-> ##[0:2] (relay_contact_output || !search_active)) else $error("relay missed search");
	chk_uv_on_loss: assert property ($fell(power_ok) && (search_active || drive_out.volt != 16'h0)
		|-> ##[1:3] undervoltage_trip) else $error("no undervoltage trip");
	chk_lock_quiet: assert property (restart_locked && !fault_reset |=> !search_active)
		else $error("search while locked");
	chk_dec_by_one: assert property (restart_remaining < $past(restart_remaining)
		|-> restart_remaining == $past(restart_remaining) - 4'h1) else $error("bad decrement");
	chk_reload_count: assert property (fault_reset && restart_locked |-> ##[1:3]
		restart_remaining == (restart_attempt_count > 4'hA ? 4'hA : restart_attempt_count)) else $error("no reload");
	chk_estop_locks: assert property (emergency_stop && (search_active || drive_out.volt != 16'h0)
		|-> ##[1:3] restart_locked) else $error("estop not locked");
	chk_over_limit: assert property (ovr_q >= 4'h5 |-> drive_out.volt <= $past(drive_out.volt) &&
		(drive_out.freq < $past(drive_out.freq) || drive_out.freq == 16'h0)) else $error("over limit drive");
	chk_under_limit: assert property (und_q >= 4'h5 |-> drive_out.volt >= $past(drive_out.volt) &&
		drive_out.freq >= $past(drive_out.freq)) else $error("under limit drive");
endmodule

// File: test/ssr_motor.sv
// Motor load model for the search loop
`timescale 1ns/1ps
module ssr_motor
	import ssr_pkg::*;
(
	// Clock
	input  wire logic       clk,
	// Drive and load
	input  wire ssr_drive_s drive,
	input  wire logic       heavy,
	output logic [15:0]     current
);
	// Current follows voltage, heavy load beats any limit
	always_ff @(posedge clk) begin
		current <= heavy ? 16'h0FA0 : {7'h00, drive.volt[15:7]};
	end
endmodule

// File: test/tb_top.sv
// Self-checking bench for the speed search and auto restart block
`timescale 1ns/1ps
module tb_top
	import ssr_pkg::*;
();
	typedef struct packed {
		logic       lk;
		logic       uv;
		logic       sa;
		logic       mo;
		logic       ro;
		logic [3:0] rem;
	} ssr_obs_s;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        run_cmd = 1'b0;
	logic        power_ok = 1'b1;
	logic        heavy = 1'b0;
	logic [2:0]  evt = 3'h0;
	logic [3:0]  sel = 4'h0;
	logic [3:0]  cnt = 4'h2;
	logic [4:0]  otf = 5'h0F;
	logic [4:0]  rof = 5'h0F;
	logic [7:0]  ilim = 8'h64;
	logic [13:0] kp = 14'h0064;
	logic [13:0] ki = 14'h03E8;
	logic [15:0] ref_f = 16'h1000;
	logic [15:0] cur;
	ssr_drive_s  drv;
	logic        mo, ro, uv, sa, lk;
	logic [3:0]  rem;
	ssr_obs_s    q[$];
	event        smp;
	int          bad_count = 0;
	int          num_checks = 0;
	always #5 clk = ~clk;
	ssr_top uut (.clk(clk), .rst_b(rst_b), .ce(1'b1), .search_case_select(sel), .search_current_limit(ilim),
		.search_prop_gain(kp), .search_integral_gain(ki), .output_terminal_function(otf),
		.relay_output_function(rof), .restart_attempt_count(cnt), .restart_delay_time(6'h00),
		.power_on_start(1'b1), .restart_after_fault_reset(1'b1), .run_cmd(run_cmd), .power_ok(power_ok),
		.fault_trip(evt[0]), .emergency_stop(evt[2]), .fault_reset(evt[1]), .ref_freq(ref_f),
		.motor_current(cur), .motor_rated_current(16'h03E8), .drive_out(drv), .multi_output_terminal(mo),
		.relay_contact_output(ro), .undervoltage_trip(uv), .search_active(sa), .restart_locked(lk),
		.restart_remaining(rem));
	ssr_motor motor (.clk(clk), .drive(drv), .heavy(heavy), .current(cur));
	task automatic chk(input ssr_obs_s seen, input ssr_obs_s exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED outputs expected=%h seen=%h", exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic pulse(input logic [2:0] m);
		@(posedge clk);
		evt <= m;
		@(posedge clk);
		evt <= 3'h0;
	endtask
	task automatic note(input logic l, input logic u, input logic s, input logic [3:0] r);
		#1;
		q.push_back({l, u, s, s && otf == 5'h0F, s && rof == 5'h0F, r});
		->smp;
		@(posedge clk);
	endtask
	task automatic await(input logic v);
		int n;
		n = 0;
		while (sa !== v && n < 4000) begin
			@(posedge clk);
			#1;
			n++;
		end
		@(posedge clk);
	endtask
	always @(smp) chk({lk, uv, sa, mo, ro, rem}, q.pop_front());
	initial begin
		cnt <= 4'($urandom(93) % 9 + 2);
		ilim <= 8'($urandom_range(200, 80));
		kp <= 14'($urandom_range(400, 50));
		ki <= 14'($urandom_range(2000, 500));
		ref_f <= 16'($urandom_range(16'hF000, 16'h0400));
		cyc(4);
		rst_b <= 1'b1;
		cyc(2);
		run_cmd <= 1'b1;
		cyc(20);
		note(0, 0, 0, 4'h0);
		run_cmd <= 1'b0;
		sel <= 4'h1;
		heavy <= 1'b1;
		cyc(5);
		run_cmd <= 1'b1;
		await(1);
		cyc(3);
		note(0, 0, 1, 4'h0);
		heavy <= 1'b0;
		await(0);
		note(0, 0, 0, 4'h0);
		pulse(3'h1);
		cyc(3);
		note(1, 0, 0, 4'h0);
		$display("test select and lock done");
		run_cmd <= 1'b0;
		sel <= 4'h2;
		pulse(3'h2);
		cyc(3);
		note(0, 0, 0, cnt);
		heavy <= 1'b1;
		run_cmd <= 1'b1;
		await(1);
		cyc(3);
		note(0, 0, 1, cnt);
		heavy <= 1'b0;
		await(0);
		for (int k = 1; k <= 10; k++) begin
			if (k <= cnt) begin
				otf <= 5'($urandom_range(20, 0));
				rof <= 5'($urandom_range(20, 5));
				heavy <= 1'b1;
				pulse(3'h1);
				await(1);
				cyc(3);
				note(0, 0, 1, cnt - 4'(k));
				heavy <= 1'b0;
				await(0);
			end
		end
		pulse(3'h1);
		cyc(3);
		note(1, 0, 0, 4'h0);
		$display("test restart count done");
		run_cmd <= 1'b0;
		sel <= 4'h4;
		pulse(3'h2);
		run_cmd <= 1'b1;
		cyc(20);
		power_ok <= 1'b0;
		cyc(4);
		note(0, 1, 0, cnt);
		heavy <= 1'b1;
		power_ok <= 1'b1;
		await(1);
		cyc(3);
		note(0, 0, 1, cnt);
		heavy <= 1'b0;
		await(0);
		power_ok <= 1'b0;
		sel <= 4'h0;
		cyc(4);
		power_ok <= 1'b1;
		cyc(4);
		note(1, 0, 0, cnt);
		$display("test power failure done");
		run_cmd <= 1'b0;
		pulse(3'h2);
		run_cmd <= 1'b1;
		cyc(20);
		pulse(3'h4);
		cyc(3);
		note(1, 0, 0, cnt);
		$display("test emergency stop done");
		cyc(5);
		finish_test();
	end
	initial begin
		cyc(60000);
		bad_count++;
		$display("CHECK FAILED watchdog expected=end seen=hang");
		finish_test();
	end
endmodule
bind ssr_top ssr_monitor mon (.*);
